// *** common/fps_pkg.sv ***
// shared constants and carrier types for the front-panel status logic
package fps_pkg;
    // timing constants
    localparam int CLK_HZ = 100_000_000;
    localparam int INIT_DELAY_MS = 100;
    localparam int INIT_CYCLES = CLK_HZ / 1000 * INIT_DELAY_MS;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    // default thresholds after reset
    localparam logic [15:0] SPEED_MATCH_RST = 16'h000a; // 10 rpm
    localparam logic [15:0] POS_DONE_RST = 16'h000a; // 10 pulses
    localparam logic [15:0] ROT_THR_RST = 16'h0014; // 20 rpm
    localparam logic [15:0] TORQ_THR_RST = 16'h000a; // 10 percent
    // key indices
    localparam int KEY_MODE = 0;
    localparam int KEY_UP = 1;
    localparam int KEY_DOWN = 2;
    localparam int KEY_AXIS = 3;
    localparam int KEY_LEFT = 4;
    localparam int NUM_KEYS = 5;
    // seven-segment patterns, bit order g..a, active high
    localparam logic [6:0] SEG_BLANK = 7'h00;
    localparam logic [6:0] SEG_CODE_OFF_0 = 7'h71; // F
    localparam logic [6:0] SEG_CODE_OFF_1 = 7'h5e; // d
    localparam logic [6:0] SEG_CODE_OFF_2 = 7'h6d; // S
    localparam logic [6:0] SEG_R = 7'h50;
    localparam logic [6:0] SEG_D = 7'h5e;
    localparam logic [6:0] SEG_Y = 7'h6e;
    localparam logic [6:0] SEG_U = 7'h1c;
    localparam logic [6:0] SEG_N = 7'h54;
    localparam logic [6:0] SEG_L = 7'h38;
    localparam logic [6:0] SEG_E = 7'h79;
    localparam logic [6:0] SEG_P = 7'h73;
    localparam logic [6:0] SEG_O = 7'h5c;
    localparam logic [6:0] SEG_T = 7'h78;
    localparam logic [6:0] SEG_A = 7'h77;
    localparam logic [6:0] SEG_ONE = 7'h06;
    // basic panel modes
    typedef enum logic [1:0] {FPS_STATE_DISP, FPS_PARAM_SET, FPS_UTILITY, FPS_MONITOR} fps_mode_t;
    // control mode of an axis
    typedef enum logic [1:0] {FPS_CTRL_SPEED, FPS_CTRL_TORQUE, FPS_CTRL_POS} fps_ctrl_t;
    // per-axis live status from the drive core
    typedef struct packed {
        logic [1:0] ctrl_mode;
        logic servo_on;
        logic ctrl_power_on;
        logic main_power_ok;
        logic init_failed;
        logic alarm;
        logic fwd_prohibit;
        logic rev_prohibit;
        logic ref_pulse_active;
        logic dev_clear_in;
        logic [15:0] motor_speed;
        logic [15:0] ref_speed;
        logic [15:0] torque_ref;
        logic [15:0] pos_error;
    } fps_axis_stat_t;
    // five display digits, leftmost first
    typedef struct packed {
        logic [6:0] d4;
        logic [6:0] d3;
        logic [6:0] d2;
        logic [6:0] d1;
        logic [6:0] d0;
    } fps_disp_t;
endpackage

// *** hdl/fps_panel.sv ***
// front-panel keypad, status display and axis indicators for a two-axis drive
`timescale 1ns/1ns
module fps_panel #(
    parameter int DEBOUNCE_CYC = fps_pkg::DEBOUNCE_CYCLES,
    parameter int INIT_CYC = fps_pkg::INIT_CYCLES,
    parameter int BLINK_CYC = fps_pkg::BLINK_CYCLES
) (
    // clock, reset and enable
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // raw keys: mode, up, down, axis, left
    input wire logic [fps_pkg::NUM_KEYS-1:0] key_raw_i,
    // menu depth from the menu core, high at the first level
    input wire logic first_level_i,
    // live status of axis A and B
    input wire fps_pkg::fps_axis_stat_t stat_a_i,
    input wire fps_pkg::fps_axis_stat_t stat_b_i,
    // thresholds
    input wire logic [15:0] speed_coincidence_threshold_i,
    input wire logic [15:0] positioning_done_threshold_i,
    input wire logic [15:0] rotation_threshold_i,
    input wire logic [15:0] torque_threshold_i,
    // panel state
    output fps_pkg::fps_mode_t mode_o,
    output logic axis_sel_o,
    output logic ready_o,
    output logic [15:0] set_value_o,
    // action pulses
    output logic alarm_clear_o,
    // display and indicators
    output fps_pkg::fps_disp_t disp_o,
    output logic led_a_o,
    output logic led_b_o
);
    // refuse counts the counters cannot serve; a zero would wrap the compare values
    generate
        if (DEBOUNCE_CYC < 1 || INIT_CYC < 1 || BLINK_CYC < 1)
        begin : g_bad_count
            $error("fps_panel: counts must be at least one");
        end
    endgenerate

    // reset synchroniser, second stage feeds the design
    logic rst_s1, rst_n;
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // debounce every key; a press pulse fires once per stable rise
    wire [fps_pkg::NUM_KEYS-1:0] key_press;
    genvar k;
    generate
        for (k = 0; k < fps_pkg::NUM_KEYS; k++)
        begin : g_key
            logic stable, raw_q;
            logic [31:0] cnt;
            always_ff @(posedge ref_clk_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    stable <= 1'b0;
                    raw_q <= 1'b0;
                    cnt <= '0;
                end
                else if (clk_en_i)
                begin
                    raw_q <= key_raw_i[k];
                    if (raw_q == stable)
                        cnt <= '0;
                    else if (cnt >= 32'(DEBOUNCE_CYC - 1))
                    begin
                        stable <= raw_q;
                        cnt <= '0;
                    end
                    else
                        cnt <= cnt + 32'h1;
                end
            end
            // press only on accepted rising edge
            assign key_press[k] = clk_en_i && raw_q && !stable && (cnt >= 32'(DEBOUNCE_CYC - 1));
        end
    endgenerate

    // power-on delay: keys ignored and display blank until done
    logic [31:0] init_cnt;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_cnt <= '0;
            ready_o <= 1'b0;
        end
        else if (clk_en_i && !ready_o)
        begin
            init_cnt <= init_cnt + 32'h1;
            if (init_cnt >= 32'(INIT_CYC - 1))
                ready_o <= 1'b1;
        end
    end

    // selected axis status
    fps_pkg::fps_axis_stat_t st;
    assign st = axis_sel_o ? stat_b_i : stat_a_i;

    wire in_alarm = st.alarm;
    wire axis_ok = ready_o && first_level_i;
    wire up_ev = ready_o && key_press[fps_pkg::KEY_UP];
    wire dn_ev = ready_o && key_press[fps_pkg::KEY_DOWN];

    // mode, axis and set value
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_o <= fps_pkg::FPS_STATE_DISP;
            axis_sel_o <= 1'b0;
            set_value_o <= '0;
            alarm_clear_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            alarm_clear_o <= 1'b0;
            if (ready_o && key_press[fps_pkg::KEY_MODE])
                mode_o <= fps_pkg::fps_mode_t'(mode_o + 2'h1);
            if (axis_ok && key_press[fps_pkg::KEY_AXIS])
                axis_sel_o <= !axis_sel_o;
            if (up_ev && !dn_ev)
                set_value_o <= set_value_o + 16'h1;
            else if (dn_ev && !up_ev)
                set_value_o <= set_value_o - 16'h1;
            if (ready_o && in_alarm && mode_o == fps_pkg::FPS_STATE_DISP && key_press[fps_pkg::KEY_LEFT])
                alarm_clear_o <= 1'b1;
        end
    end

    // absolute difference and control mode helpers
    wire [15:0] spd_gap = (st.motor_speed > st.ref_speed) ? st.motor_speed - st.ref_speed
                                                          : st.ref_speed - st.motor_speed;
    wire is_pos = st.ctrl_mode == fps_pkg::FPS_CTRL_POS;
    wire is_torq = st.ctrl_mode == fps_pkg::FPS_CTRL_TORQUE;

    // status segments a..g; a, d and e follow the control mode
    wire [6:0] bits;
    assign bits[0] = is_pos ? (st.pos_error < positioning_done_threshold_i)
                            : (is_torq || spd_gap <= speed_coincidence_threshold_i);
    assign bits[1] = !st.servo_on;
    assign bits[2] = st.ctrl_power_on;
    assign bits[3] = is_pos ? st.ref_pulse_active
                            : (st.ref_speed > rotation_threshold_i);
    assign bits[4] = is_pos ? st.dev_clear_in
                            : (st.torque_ref > torque_threshold_i);
    assign bits[5] = st.main_power_ok;
    assign bits[6] = st.motor_speed > rotation_threshold_i;

    // code field selection, alarm has highest priority
    logic [20:0] code;
    assign code = st.alarm ? {fps_pkg::SEG_BLANK, fps_pkg::SEG_A, fps_pkg::SEG_L}
                : st.init_failed ? {fps_pkg::SEG_R, fps_pkg::SEG_D, fps_pkg::SEG_Y}
                : (st.fwd_prohibit && st.rev_prohibit) ? {fps_pkg::SEG_L, fps_pkg::SEG_O, fps_pkg::SEG_T}
                : st.fwd_prohibit ? {fps_pkg::SEG_P, fps_pkg::SEG_O, fps_pkg::SEG_T}
                : st.rev_prohibit ? {fps_pkg::SEG_N, fps_pkg::SEG_O, fps_pkg::SEG_T}
                : st.servo_on ? {fps_pkg::SEG_R, fps_pkg::SEG_U, fps_pkg::SEG_N}
                : {fps_pkg::SEG_CODE_OFF_0, fps_pkg::SEG_CODE_OFF_1, fps_pkg::SEG_CODE_OFF_2};

    // second digit names the axis; in state display the leftmost carries bits and the last three the code, other modes show the mode in the last
    fps_pkg::fps_disp_t next_disp;
    assign next_disp = !ready_o ? '0
                     : (mode_o == fps_pkg::FPS_STATE_DISP)
                       ? {bits, (axis_sel_o ? fps_pkg::SEG_D : fps_pkg::SEG_A), code}
                       : {fps_pkg::SEG_BLANK, (axis_sel_o ? fps_pkg::SEG_D : fps_pkg::SEG_A),
                          fps_pkg::SEG_BLANK, fps_pkg::SEG_BLANK, {5'h00, mode_o}};

    // blink divider
    logic [31:0] blink_cnt;
    logic blink;
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (blink_cnt >= 32'(BLINK_CYC - 1))
            begin
                blink_cnt <= '0;
                blink <= !blink;
            end
            else
                blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // indicator levels per axis
    wire next_led_a = !axis_sel_o ? 1'b1 : (stat_a_i.alarm & blink);
    wire next_led_b = axis_sel_o ? 1'b1 : (stat_b_i.alarm & blink);

    // registered display and indicators
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            disp_o <= '0;
            led_a_o <= 1'b0;
            led_b_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            disp_o <= next_disp;
            led_a_o <= ready_o & next_led_a;
            led_b_o <= ready_o & next_led_b;
        end
    end

    // checks
    mode_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (ready_o && key_press[fps_pkg::KEY_MODE]) |=> mode_o == fps_pkg::fps_mode_t'($past(mode_o) + 2'h1))
        else $error("mode did not advance");
    axis_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !first_level_i |=> $stable(axis_sel_o))
        else $error("axis changed outside first level");
    up_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (up_ev && !dn_ev) |=> set_value_o == $past(set_value_o) + 16'h1)
        else $error("up did not increment");
    down_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (dn_ev && !up_ev) |=> set_value_o == $past(set_value_o) - 16'h1)
        else $error("down did not decrement");
    led_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && !axis_sel_o) |=> led_a_o)
        else $error("selected axis indicator dark");
    led_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && axis_sel_o && !stat_a_i.alarm) |=> !led_a_o)
        else $error("idle axis indicator lit");
    servo_seg_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && mode_o == fps_pkg::FPS_STATE_DISP) |=> disp_o.d4[1] == !$past(st.servo_on))
        else $error("servo off segment wrong");
    // only the rising edge counts: a frozen enable may hold the pulse high
    clear_req_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(alarm_clear_o) |-> $past(in_alarm) && $past(key_press[fps_pkg::KEY_LEFT])
            && $past(mode_o) == fps_pkg::FPS_STATE_DISP)
        else $error("alarm clear without cause");
    led_b_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && axis_sel_o) |=> led_b_o)
        else $error("selected axis b indicator dark");
    led_b_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && !axis_sel_o && !stat_b_i.alarm) |=> !led_b_o)
        else $error("idle axis b indicator lit");
    // an alarmed idle axis follows the slow blink phase
    led_blink_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && axis_sel_o && stat_a_i.alarm) |=> led_a_o == $past(blink))
        else $error("alarmed idle indicator not blinking");
    blink_rate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && blink_cnt == 32'(BLINK_CYC - 1)) |=> blink != $past(blink))
        else $error("blink phase did not toggle");
    blink_bound_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        blink_cnt < 32'(BLINK_CYC))
        else $error("blink divider out of range");
    // nothing shows before the power-on delay ends
    init_blank_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        !ready_o |-> disp_o == '0 && !led_a_o && !led_b_o)
        else $error("display lit before ready");
    ready_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        ready_o |=> ready_o)
        else $error("ready dropped");
    // one press pulse per accepted rise, never two cycles running
    key_once_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (key_press != '0) |=> (key_press & $past(key_press)) == '0)
        else $error("key press repeated");
    key_held_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (key_press[fps_pkg::KEY_MODE] && $past(clk_en_i)) |-> $past(key_raw_i[fps_pkg::KEY_MODE]))
        else $error("press without held key");
    seg_power_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && mode_o == fps_pkg::FPS_STATE_DISP) |=> disp_o.d4[2] == $past(st.ctrl_power_on))
        else $error("control power segment wrong");
    seg_rot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && mode_o == fps_pkg::FPS_STATE_DISP)
            |=> disp_o.d4[6] == ($past(st.motor_speed) > $past(rotation_threshold_i)))
        else $error("rotation segment wrong");
    seg_torq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (clk_en_i && ready_o && mode_o == fps_pkg::FPS_STATE_DISP && is_torq) |=> disp_o.d4[0])
        else $error("torque coincidence segment dark");
endmodule

// *** sim/fps_operator.sv ***
// operator model that presses front-panel keys with contact chatter
`timescale 1ns/1ns
module fps_operator #(
    parameter int DEB = 4
) (
    // clock
    input wire logic clk_i,
    // raw key levels toward the panel
    output logic [fps_pkg::NUM_KEYS-1:0] key_raw_o
);
    initial key_raw_o = '0;

    // one press: a chatter burst, a hold well past the filter, then a clean release
    task automatic press(input logic [fps_pkg::NUM_KEYS-1:0] m);
        @(posedge clk_i) key_raw_o <= m;
        @(posedge clk_i) key_raw_o <= '0;
        @(posedge clk_i) key_raw_o <= m;
        repeat (DEB + 4) @(posedge clk_i);
        key_raw_o <= '0;
        // a real finger lets go before pressing again
        repeat (DEB + 6) @(posedge clk_i);
    endtask

    // contact bounce only, shorter than any filter should accept
    task automatic glitch(input logic [fps_pkg::NUM_KEYS-1:0] m);
        @(posedge clk_i) key_raw_o <= m;
        @(posedge clk_i);
        key_raw_o <= '0;
        repeat (DEB + 6) @(posedge clk_i);
    endtask
endmodule

// *** sim/front_panel_status_ui_bench.sv ***
// self-checking bench for the front-panel status logic
`timescale 1ns/1ns
module front_panel_status_ui_bench;
    localparam int DEB = 4; // short filter keeps the run brief
    localparam logic [20:0] OFF_CODE = {fps_pkg::SEG_CODE_OFF_0, fps_pkg::SEG_CODE_OFF_1, fps_pkg::SEG_CODE_OFF_2};
    // clock, reset and panel inputs
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic first_level_i = 1'b1;
    logic clk_en = 1'b1;
    // thresholds start at their reset values, later rounds move them
    logic [15:0] thr_spd = fps_pkg::SPEED_MATCH_RST;
    logic [15:0] thr_pos = fps_pkg::POS_DONE_RST;
    logic [15:0] thr_rot = fps_pkg::ROT_THR_RST;
    logic [15:0] thr_torq = fps_pkg::TORQ_THR_RST;
    logic [4:0] keys;
    fps_pkg::fps_axis_stat_t sa = '0;
    fps_pkg::fps_axis_stat_t sb = '0;
    // design outputs
    fps_pkg::fps_mode_t mode_o;
    logic axis_sel_o, ready_o, alarm_clear_o, led_a_o, led_b_o;
    logic [15:0] set_value_o;
    fps_pkg::fps_disp_t disp_o;
    // reference model state and bookkeeping
    int m_mode = 0, m_axis = 0, m_set = 0, num_errors = 0, checked = 0, cyc = 0, clr = 0;
    logic [15:0] rnd = 16'hc636;
    logic [20:0] codes [7];

    always #5 ref_clk_i = ~ref_clk_i;

    fps_panel #(.DEBOUNCE_CYC(DEB), .INIT_CYC(8), .BLINK_CYC(4)) u_dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en), .key_raw_i(keys),
        .first_level_i(first_level_i), .stat_a_i(sa), .stat_b_i(sb),
        .speed_coincidence_threshold_i(thr_spd), .positioning_done_threshold_i(thr_pos),
        .rotation_threshold_i(thr_rot), .torque_threshold_i(thr_torq), .mode_o(mode_o), .axis_sel_o(axis_sel_o),
        .ready_o(ready_o), .set_value_o(set_value_o), .alarm_clear_o(alarm_clear_o), .disp_o(disp_o),
        .led_a_o(led_a_o), .led_b_o(led_b_o));
    fps_operator #(.DEB(DEB)) u_op (.clk_i(ref_clk_i), .key_raw_o(keys));

    // hang guard and alarm-clear pulse counter
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (alarm_clear_o === 1'b1)
            clr++;
        if (cyc == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // expected status segments, bit 0 is segment 1
    function automatic logic [6:0] segs(input fps_pkg::fps_axis_stat_t s);
        int d;
        logic pos;
        d = int'(s.motor_speed) - int'(s.ref_speed);
        pos = s.ctrl_mode == 2'h2;
        if (d < 0)
            d = -d;
        segs[0] = pos ? s.pos_error < thr_pos : s.ctrl_mode == 2'h1 || d <= int'(thr_spd);
        segs[1] = !s.servo_on;
        segs[2] = s.ctrl_power_on;
        segs[3] = pos ? s.ref_pulse_active : s.ref_speed > thr_rot;
        segs[4] = pos ? s.dev_clear_in : s.torque_ref > thr_torq;
        segs[5] = s.main_power_ok;
        segs[6] = s.motor_speed > thr_rot;
    endfunction

    task automatic chk(input string n, input logic [34:0] e, input logic [34:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // status words change right after an edge, then settle through the display pipe
    task automatic put(input fps_pkg::fps_axis_stat_t a, input fps_pkg::fps_axis_stat_t b);
        @(posedge ref_clk_i);
        sa <= a;
        sb <= b;
        repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic state_chk();
        chk("mode", 35'(m_mode), 35'(mode_o));
        chk("axis", 35'(m_axis), 35'(axis_sel_o));
        chk("set value", 35'(m_set), 35'(set_value_o));
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        fps_pkg::fps_axis_stat_t t;
        int hi;
        int c0;
        logic [15:0] tv;
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        // still inside the power-on delay: dark display, not ready
        repeat (4) @(posedge ref_clk_i);
        chk("ready early", 35'h0, 35'(ready_o));
        chk("blank display", 35'h0, 35'(disp_o));
        for (int n = 0; n < 200 && ready_o !== 1'b1; n++)
            @(posedge ref_clk_i);
        chk("ready", 35'h1, 35'(ready_o));
        state_chk();
        // a bounce shorter than the filter must not count
        u_op.glitch(5'h01);
        state_chk();
        for (int i = 0; i < 4; i++)
        begin
            u_op.press(5'h01);
            m_mode = (m_mode + 1) % 4;
            state_chk();
            if (m_mode != 0)
                chk("mode digit", 35'(m_mode), 35'(disp_o.d0));
            if (i == 0)
            begin
                // three up, one down, then both together which does nothing
                repeat (3) u_op.press(5'h02);
                u_op.press(5'h04);
                u_op.press(5'h06);
                m_set = 2;
                state_chk();
            end
        end
        // a low clock enable freezes the panel, so a whole press is lost
        clk_en <= 1'b0;
        u_op.press(5'h01);
        state_chk();
        clk_en <= 1'b1;
        $display("test keys done");
        // random status words in all three control modes, values near the thresholds
        for (int i = 0; i < 24; i++)
        begin
            t = '0;
            rnd = nxt(rnd);
            t.ctrl_mode = 2'(i % 3);
            {t.servo_on, t.ctrl_power_on, t.main_power_ok, t.ref_pulse_active, t.dev_clear_in} = rnd[4:0];
            rnd = nxt(rnd);
            t.motor_speed = 16'(rnd[5:0]);
            t.ref_speed = 16'(rnd[11:6]);
            rnd = nxt(rnd);
            t.torque_ref = 16'(rnd[5:0]);
            t.pos_error = 16'(rnd[11:6]);
            // later rounds move the compare levels as well
            tv = 16'(rnd[15:10]);
            thr_spd <= (i < 12) ? fps_pkg::SPEED_MATCH_RST : tv;
            thr_pos <= (i < 12) ? fps_pkg::POS_DONE_RST : tv;
            thr_rot <= (i < 12) ? fps_pkg::ROT_THR_RST : tv;
            thr_torq <= (i < 12) ? fps_pkg::TORQ_THR_RST : tv;
            put(t, '0);
            chk("status digit", 35'(segs(t)), 35'(disp_o.d4));
        end
        // each operating state gives its own code
        for (int k = 0; k < 7; k++)
        begin
            t = '0;
            t.ctrl_power_on = 1'b1;
            t.servo_on = k inside {2, 4, 5, 6};
            t.init_failed = k == 1;
            t.alarm = k == 3;
            t.fwd_prohibit = k == 4 || k == 6;
            t.rev_prohibit = k >= 5;
            put(t, '0);
            codes[k] = {disp_o.d2, disp_o.d1, disp_o.d0};
            for (int j = 0; j < k; j++)
                chk("code differs", 35'h1, 35'(codes[j] !== codes[k]));
        end
        chk("servo off code", 35'(OFF_CODE), 35'(codes[0]));
        // left key clears only while an alarm is present
        t = '0;
        t.alarm = 1'b1;
        put(t, '0);
        c0 = clr;
        u_op.press(5'h10);
        chk("clear pulses", 35'h1, 35'(clr - c0));
        put('0, '0);
        u_op.press(5'h10);
        chk("clear pulses", 35'h1, 35'(clr - c0));
        $display("test display done");
        chk("led a", 35'h1, 35'(led_a_o));
        chk("led b", 35'h0, 35'(led_b_o));
        put('0, t);
        hi = 0;
        for (int n = 0; n < 20; n++)
        begin
            @(posedge ref_clk_i);
            hi += int'(led_b_o === 1'b1);
        end
        chk("blink", 35'h1, 35'(hi > 0 && hi < 20));
        put('0, '0);
        u_op.press(5'h08);
        m_axis = 1;
        state_chk();
        chk("axis letter", 35'(fps_pkg::SEG_D), 35'(disp_o.d3));
        chk("led b", 35'h1, 35'(led_b_o));
        chk("led a", 35'h0, 35'(led_a_o));
        // axis key is refused away from the first-level menu
        @(posedge ref_clk_i);
        first_level_i <= 1'b0;
        u_op.press(5'h08);
        state_chk();
        @(posedge ref_clk_i);
        first_level_i <= 1'b1;
        u_op.press(5'h08);
        m_axis = 0;
        state_chk();
        chk("axis letter", 35'(fps_pkg::SEG_A), 35'(disp_o.d3));
        $display("test axis done");
        // a second reset mid-run brings back the power-on state
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        m_set = 0;
        repeat (20) @(posedge ref_clk_i);
        chk("ready", 35'h1, 35'(ready_o));
        state_chk();
        $display("test reset done");
        give_verdict();
    end
endmodule
